// ===== logic/sosp_pkg.sv
// Constants shared by the streaming output source port and its testbench.
package sosp_pkg;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int APB_AW = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int LVL_W = 6;
	localparam int EMPTY_W = 5;
	localparam int MAX_LAT = 8;
	localparam int BYTE_W = 8;

	localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFS_SIDE = 8'h04;
	localparam logic [APB_AW-1:0] OFS_DATA = 8'h08;
	localparam logic [APB_AW-1:0] OFS_STAT = 8'h0c;
	localparam logic [APB_AW-1:0] OFS_CNT = 8'h10;

	localparam int CTRL_HOF = 0;
	localparam int CTRL_NB = 1;
	localparam int CTRL_W = 2;

	localparam int SIDE_SOP = 0;
	localparam int SIDE_EOP = 1;
	localparam int SIDE_EMP_LSB = 8;

	localparam int STAT_NB_OK = 0;
	localparam int STAT_NB_TRIED = 1;
	localparam int STAT_FULL = 2;
	localparam int STAT_EMPTY = 3;
	localparam int STAT_OVALID = 4;
	localparam int STAT_SNK_RDY = 5;
	localparam int STAT_IN_PKT = 6;
	localparam int STAT_PKT_ERR = 7;
	localparam int STAT_LVL_LSB = 8;

	localparam logic [31:0] CNT_RST = 32'h0000_0000;
	localparam logic [31:0] CNT_ONE = 32'h0000_0001;
endpackage

// ===== logic/sosp_fifo.sv
// Synchronous FIFO that buffers outgoing stream words.
`timescale 1ns/1ns
`default_nettype none
module sosp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	// Depth is taken as a power of two so the pointers wrap by themselves.
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} sosp_fifo_st_t;

	sosp_fifo_st_t st_r;
	sosp_fifo_st_t st_nxt;
	logic wr;
	logic rd;

	assign in_ready = st_r.cnt != FULL_CNT;
	assign out_valid = st_r.cnt != '0;
	assign out_data = st_r.mem[st_r.rp];
	assign level = st_r.cnt;
	assign wr = in_valid & in_ready;
	assign rd = out_valid & out_ready;

	always_comb begin
		st_nxt = st_r;
		if (wr) begin
			st_nxt.mem[st_r.wp] = in_data;
			st_nxt.wp = st_r.wp + 1'b1;
		end
		if (rd) begin
			st_nxt.rp = st_r.rp + 1'b1;
		end
		if (wr && !rd) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end else if (rd && !wr) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// ===== logic/sosp_top.sv
// Streaming output source port with APB registers and a word buffer.
// Operation
// [RULE1] Ready latency 0 to 8, default 0; valid only inside the latency window.
// [RULE2] Symbol width divides the word; unset or invalid means one symbol per word.
// [RULE3] Full edition obeys symbol order setting; basic edition is always little endian.
// [RULE4] High order first puts the first symbol in the top bits.
// [RULE5] Packet option exposes start and end of packet beside each word.
// [RULE6] Empty output only on request and only with several symbols per word.
// [RULE7] On a packet's last word empty counts the symbols carrying no data.
// [RULE8] Unused symbols sit low or high as the symbol order selects.
// [RULE9] Ready input exists by default; the option can remove backpressure.
// [RULE10] Without ready the sink takes every valid word; latency is then zero.
// [RULE11] A blocking write stalls the writer until the word is accepted.
// [RULE12] Write with packet flags exists only with the packet option.
// [RULE13] Write with flags and empty needs both packet and empty options.
// [RULE14] Non-blocking write never stalls and reports whether ready was high.
// [RULE15] Data bus width equals the carried element size.
// [RULE16] A word moves when valid meets acceptance and holds stable until then.
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sosp_top #(
	parameter int READY_LAT = 0,
	parameter int SYM_W = sosp_pkg::DATA_W,
	parameter bit FULL_EDITION = 1'b1,
	parameter bit HOF_RESET = 1'b0,
	parameter bit PACKETS = 1'b0,
	parameter bit EMPTY_EN = 1'b0,
	parameter bit READY_EN = 1'b1
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [sosp_pkg::APB_AW-1:0] PADDR,
	input wire logic [sosp_pkg::DATA_W-1:0] PWDATA,
	input wire logic [sosp_pkg::STRB_W-1:0] PSTRB,
	output logic [sosp_pkg::DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic [sosp_pkg::DATA_W-1:0] SRC_DATA,
	output logic SRC_VALID,
	output logic SRC_SOP,
	output logic SRC_EOP,
	output logic [sosp_pkg::EMPTY_W-1:0] SRC_EMPTY,
	input wire logic SNK_READY
);
	localparam int DW = sosp_pkg::DATA_W;
	localparam int EW = sosp_pkg::EMPTY_W;
	localparam int SYM_EFF = (SYM_W > 0 && (DW % SYM_W) == 0) ? SYM_W : DW; // RULE2
	localparam int NSYM = DW / SYM_EFF;
	localparam int LAT_CLIP = (READY_LAT > sosp_pkg::MAX_LAT) ? sosp_pkg::MAX_LAT : READY_LAT;
	localparam int LAT = READY_EN ? LAT_CLIP : 0; // RULE10
	localparam int PIDX = (LAT > 0) ? LAT - 1 : 0;
	localparam bit PKT_ON = PACKETS;
	localparam bit EMP_ON = PACKETS && EMPTY_EN && (NSYM > 1); // RULE6
	localparam int ENT_W = DW + 2 + EW;
	localparam logic [EW-1:0] EMP_MAX = EW'(NSYM - 1);
	localparam logic [sosp_pkg::CTRL_W-1:0] CTRL_RST = {1'b0, HOF_RESET};

	typedef enum logic [2:0] {
		R_CTRL,
		R_SIDE,
		R_DATA,
		R_STAT,
		R_CNT,
		R_NONE
	} sosp_reg_t;

	typedef struct packed {
		logic [sosp_pkg::CTRL_W-1:0] ctrl;
		logic sop;
		logic eop;
		logic [EW-1:0] empty;
		logic nb_ok;
		logic nb_tried;
		logic [sosp_pkg::MAX_LAT-1:0] rdy_hist;
		logic o_valid;
		logic [DW-1:0] o_data;
		logic o_sop;
		logic o_eop;
		logic [EW-1:0] o_empty;
		logic [31:0] xfer_cnt;
		logic in_pkt;
		logic pkt_err;
		logic [DW-1:0] rdata;
	} sosp_st_t;

	function automatic sosp_reg_t reg_of(input logic [sosp_pkg::APB_AW-1:0] a);
		if (a == sosp_pkg::OFS_CTRL) begin
			return R_CTRL;
		end else if (a == sosp_pkg::OFS_SIDE) begin
			return R_SIDE;
		end else if (a == sosp_pkg::OFS_DATA) begin
			return R_DATA;
		end else if (a == sosp_pkg::OFS_STAT) begin
			return R_STAT;
		end else if (a == sosp_pkg::OFS_CNT) begin
			return R_CNT;
		end else begin
			return R_NONE;
		end
	endfunction

	// Byte lanes with a clear strobe keep their old contents.
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_v,
		input logic [DW-1:0] new_v, input logic [sosp_pkg::STRB_W-1:0] strb);
		logic [DW-1:0] r;
		r = old_v;
		for (int b = 0; b < sosp_pkg::STRB_W; b++) begin
			if (strb[b]) begin
				r[b*sosp_pkg::BYTE_W +: sosp_pkg::BYTE_W] =
					new_v[b*sosp_pkg::BYTE_W +: sosp_pkg::BYTE_W];
			end
		end
		return r;
	endfunction

	// Software supplies the first symbol in the low bits; reversing moves it to
	// the top and also carries the unused trailing symbols to the low bits.
	function automatic logic [DW-1:0] order(input logic [DW-1:0] d, input logic hof);
		logic [DW-1:0] r;
		r = d;
		if (hof) begin
			for (int i = 0; i < DW; i++) begin
				r[i] = d[(NSYM - 1 - i / SYM_EFF) * SYM_EFF + i % SYM_EFF]; // RULE4 RULE8
			end
		end
		return r;
	endfunction

	sosp_st_t st_r;
	sosp_st_t st_nxt;
	sosp_reg_t which;
	logic setup;
	logic access;
	logic data_wr;
	logic nb_mode;
	logic hof_eff;
	logic ready_eff;
	logic perm_next;
	logic fire;
	logic load;
	logic push;
	logic sop_in;
	logic eop_in;
	logic [EW-1:0] emp_in;
	logic [EW-1:0] emp_side;
	logic f_in_ready;
	logic f_out_valid;
	logic [ENT_W-1:0] f_out_data;
	logic [sosp_pkg::LVL_W-1:0] f_level;
	logic [DW-1:0] side_word;
	logic [DW-1:0] stat_word;
	logic [sosp_pkg::MAX_LAT:0] rdy_ext;
	logic [DW-1:0] ctrl_m;
	logic [DW-1:0] side_m;

	assign which = reg_of(PADDR);
	assign setup = PSEL & ~PENABLE;
	assign access = PSEL & PENABLE;
	assign nb_mode = st_r.ctrl[sosp_pkg::CTRL_NB];
	assign hof_eff = FULL_EDITION & st_r.ctrl[sosp_pkg::CTRL_HOF]; // RULE3
	assign ready_eff = READY_EN ? SNK_READY : 1'b1; // RULE9 RULE10
	assign data_wr = access & PWRITE & (which == R_DATA);

	// A blocking push holds the bus until the buffer takes the word, so the
	// writing software cannot run ahead; a non-blocking push always completes.
	assign PREADY = (data_wr && !nb_mode) ? f_in_ready : 1'b1; // RULE11
	assign PSLVERR = access & (which == R_NONE);
	assign PRDATA = st_r.rdata;

	// Non-blocking pushes succeed only when the sink shows ready right now.
	assign push = data_wr & f_in_ready & (nb_mode ? ready_eff : 1'b1); // RULE11 RULE14

	assign emp_side = st_r.empty;
	assign sop_in = PKT_ON & st_r.sop; // RULE5 RULE12
	assign eop_in = PKT_ON & st_r.eop; // RULE12
	assign emp_in = (!EMP_ON || !eop_in) ? '0 : // RULE13 RULE7
		((emp_side > EMP_MAX) ? EMP_MAX : emp_side);

	sosp_fifo #(
		.WIDTH(ENT_W),
		.DEPTH(sosp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(REF_CLK),
		.rst_n(RESET_N),
		.in_valid(push),
		.in_ready(f_in_ready),
		.in_data({sop_in, eop_in, emp_in, PWDATA}), // RULE15
		.out_valid(f_out_valid),
		.out_ready(load),
		.out_data(f_out_data),
		.level(f_level)
	);

	// Index 0 is ready in this cycle, index k is ready k cycles ago.
	assign rdy_ext = {st_r.rdy_hist, ready_eff};
	assign perm_next = (LAT == 0) ? 1'b1 : rdy_ext[PIDX]; // RULE1

	// With latency zero the word waits on valid and ready together; with a
	// latency, valid is only raised in a cycle that ready already granted.
	assign fire = st_r.o_valid & ((LAT == 0) ? ready_eff : 1'b1); // RULE16
	assign load = f_out_valid & ((LAT == 0) ? (~st_r.o_valid | fire) : perm_next); // RULE1

	assign side_word = {
		{(DW - sosp_pkg::SIDE_EMP_LSB - EW){1'b0}},
		st_r.empty,
		{(sosp_pkg::SIDE_EMP_LSB - 2){1'b0}},
		st_r.eop,
		st_r.sop
	};

	assign stat_word = {
		{(DW - sosp_pkg::STAT_LVL_LSB - sosp_pkg::LVL_W){1'b0}},
		f_level,
		st_r.pkt_err,
		st_r.in_pkt,
		ready_eff,
		st_r.o_valid,
		~f_out_valid,
		~f_in_ready,
		st_r.nb_tried,
		st_r.nb_ok
	};

	assign ctrl_m = merge({{(DW - sosp_pkg::CTRL_W){1'b0}}, st_r.ctrl}, PWDATA, PSTRB);
	assign side_m = merge(side_word, PWDATA, PSTRB);

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdy_hist = rdy_ext[sosp_pkg::MAX_LAT-1:0];

		if (setup) begin
			case (which)
				R_CTRL: begin
					st_nxt.rdata = {{(DW - sosp_pkg::CTRL_W){1'b0}}, st_r.ctrl};
				end
				R_SIDE: begin
					st_nxt.rdata = side_word;
				end
				R_STAT: begin
					st_nxt.rdata = stat_word;
				end
				R_CNT: begin
					st_nxt.rdata = st_r.xfer_cnt;
				end
				default: begin
					st_nxt.rdata = '0;
				end
			endcase
		end

		if (access && PWRITE) begin
			case (which)
				R_CTRL: begin
					st_nxt.ctrl = ctrl_m[sosp_pkg::CTRL_W-1:0];
				end
				R_SIDE: begin
					st_nxt.empty = side_m[sosp_pkg::SIDE_EMP_LSB +: EW];
					st_nxt.eop = side_m[sosp_pkg::SIDE_EOP];
					st_nxt.sop = side_m[sosp_pkg::SIDE_SOP];
				end
				R_STAT: begin
					if (PWDATA[sosp_pkg::STAT_PKT_ERR] && PSTRB[0]) begin
						st_nxt.pkt_err = 1'b0;
					end
				end
				R_CNT: begin
					st_nxt.xfer_cnt = sosp_pkg::CNT_RST;
				end
				default: begin
				end
			endcase
		end

		if (data_wr && nb_mode) begin
			st_nxt.nb_tried = 1'b1;
			st_nxt.nb_ok = push; // RULE14
		end

		if (fire) begin
			// Counting on top of a clear in the same cycle leaves the count at one.
			st_nxt.xfer_cnt = st_nxt.xfer_cnt + sosp_pkg::CNT_ONE;
			if (st_r.o_sop && st_r.in_pkt) begin
				st_nxt.pkt_err = 1'b1;
			end
			if (PKT_ON && !st_r.o_sop && !st_r.in_pkt) begin
				st_nxt.pkt_err = 1'b1;
			end
			if (st_r.o_eop) begin
				st_nxt.in_pkt = 1'b0;
			end else if (st_r.o_sop) begin
				st_nxt.in_pkt = 1'b1;
			end
			st_nxt.o_valid = 1'b0;
		end

		// Words leave in buffer order; the symbol order is applied as each one
		// enters the output stage, so a change of it takes effect between words.
		if (load) begin
			st_nxt.o_valid = 1'b1;
			st_nxt.o_data = order(f_out_data[DW-1:0], hof_eff); // RULE3 RULE4
			st_nxt.o_empty = f_out_data[DW +: EW]; // RULE7 RULE8
			st_nxt.o_eop = f_out_data[DW + EW];
			st_nxt.o_sop = f_out_data[DW + EW + 1];
		end
	end

	always_ff @(posedge REF_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_r <= '0;
			st_r.ctrl <= CTRL_RST;
			st_r.xfer_cnt <= sosp_pkg::CNT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs hold while valid waits for acceptance.
	assign SRC_VALID = st_r.o_valid; // RULE16
	assign SRC_DATA = st_r.o_data;
	assign SRC_SOP = st_r.o_sop; // RULE5
	assign SRC_EOP = st_r.o_eop;
	assign SRC_EMPTY = st_r.o_empty; // RULE6
endmodule
`default_nettype wire

// ===== testbench/sosp_top_asserts.sv
// Concurrent checks on the pins of the streaming source port.
`timescale 1ns/1ns
`default_nettype none
module sosp_asserts #(
	parameter int READY_LAT = 0,
	parameter int SYM_W = 32
) (
	input wire logic REF_CLK,
	input wire logic RESET_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [sosp_pkg::APB_AW-1:0] PADDR,
	input wire logic PREADY,
	input wire logic [sosp_pkg::DATA_W-1:0] SRC_DATA,
	input wire logic SRC_VALID,
	input wire logic SRC_SOP,
	input wire logic SRC_EOP,
	input wire logic [sosp_pkg::EMPTY_W-1:0] SRC_EMPTY,
	input wire logic SNK_READY
);
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (!RESET_N);
	hold_word_a: assert property (READY_LAT == 0 && SRC_VALID && !SNK_READY
		|=> SRC_VALID && $stable(SRC_DATA)) else $error("word changed while held");
	side_hold_a: assert property (READY_LAT == 0 && SRC_VALID && !SNK_READY
		|=> $stable({SRC_SOP, SRC_EOP, SRC_EMPTY})) else $error("sideband changed while held");
	valid_fall_a: assert property (READY_LAT == 0 && $fell(SRC_VALID)
		|-> $past(SNK_READY)) else $error("valid dropped without a transfer");
	empty_eop_a: assert property (SRC_VALID && SRC_EMPTY != 0 |-> SRC_EOP)
		else $error("empty count outside a final word");
	empty_max_a: assert property (SRC_VALID |-> SRC_EMPTY < sosp_pkg::DATA_W / SYM_W)
		else $error("empty count exceeds symbols");
	pready_cause_a: assert property (!PREADY
		|-> PSEL && PENABLE && PWRITE && PADDR == sosp_pkg::OFS_DATA)
		else $error("wait state outside a data push");
	pready_room_a: assert property (!PREADY && SRC_VALID && SNK_READY
		|-> ##[1:3] PREADY) else $error("push still stalled after room");
	pready_bound_a: assert property (!PREADY |-> ##[1:300] PREADY)
		else $error("push stalled too long");
	reset_quiet_a: assert property ($rose(RESET_N) |-> !SRC_VALID && PREADY)
		else $error("outputs active after reset");
endmodule
bind sosp_top sosp_asserts #(.READY_LAT(READY_LAT), .SYM_W(SYM_W)) u_chk (.REF_CLK, .RESET_N,
	.PSEL, .PENABLE, .PWRITE, .PADDR, .PREADY, .SRC_DATA, .SRC_VALID, .SRC_SOP, .SRC_EOP,
	.SRC_EMPTY, .SNK_READY);
`default_nettype wire

// ===== testbench/sosp_snk.sv
// Downstream sink model that records every accepted word.
`timescale 1ns/1ns
`default_nettype none
module sosp_snk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic slow,
	input wire logic valid,
	input wire logic [31:0] data,
	input wire logic [6:0] side,
	output logic ready
);
	logic [31:0] dq[$];
	logic [6:0] sq[$];
	// Slow mode drops ready every other cycle so held words are exercised.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
		end else begin
			ready <= !stall && (!slow || !ready);
			if (valid && ready) begin
				dq.push_back(data);
				sq.push_back(side);
			end
		end
	end
endmodule
`default_nettype wire

// ===== testbench/test_streaming_output_source_port.sv
// Register-level testbench for the streaming source port.
`timescale 1ns/1ns
`default_nettype none
module test_streaming_output_source_port;
	logic clk, pready, pslverr, valid, sop, eop, rdy, err;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic stall = 1'b0;
	logic slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, data, rd;
	logic [4:0] empty;
	int num_errors = 0;
	int samples_checked = 0;
	time t_done, t_rel;
	sosp_top #(.SYM_W(8), .PACKETS(1'b1), .EMPTY_EN(1'b1)) DUT (.REF_CLK(clk),
		.RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
		.PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.SRC_DATA(data), .SRC_VALID(valid), .SRC_SOP(sop), .SRC_EOP(eop), .SRC_EMPTY(empty),
		.SNK_READY(rdy));
	sosp_snk u_snk (.clk(clk), .rst_n(rst_n), .stall(stall), .slow(slow), .valid(valid),
		.data(data), .side({sop, eop, empty}), .ready(rdy));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk iff pready === 1'b1);
		rd = prdata;
		err = pslverr;
		pen <= 1'b0;
		psel <= 1'b0;
	endtask
	task automatic wait_n(input int n);
		for (int k = 0; k < 500 && u_snk.dq.size() < n; k++) begin
			@(posedge clk);
		end
		chk(u_snk.dq.size(), n);
	endtask
	task automatic finish_test;
		$display("checks=%0d errors=%0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, sosp_pkg::OFS_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		slow <= 1'b1;
		// Both symbol orders, with a short final word.
		for (int h = 0; h < 2; h++) begin
			apb(1'b1, sosp_pkg::OFS_CTRL, h);
			apb(1'b1, sosp_pkg::OFS_SIDE, 32'h1);
			apb(1'b1, sosp_pkg::OFS_DATA, 32'h44332211);
			apb(1'b1, sosp_pkg::OFS_SIDE, 32'h102);
			apb(1'b1, sosp_pkg::OFS_DATA, 32'h00665544);
			wait_n(2);
			chk(u_snk.dq.pop_front(), h ? 32'h11223344 : 32'h44332211);
			chk(u_snk.sq.pop_front(), 32'h40);
			chk(u_snk.dq.pop_front(), h ? 32'h44556600 : 32'h00665544);
			chk(u_snk.sq.pop_front(), 32'h21);
		end
		apb(1'b1, sosp_pkg::OFS_CTRL, 32'h0);
		apb(1'b1, sosp_pkg::OFS_SIDE, 32'h0);
		slow <= 1'b0;
		stall <= 1'b1;
		// The buffer fills while the sink stalls; the writer must wait.
		fork
			begin
				for (int i = 0; i < 40; i++) apb(1'b1, sosp_pkg::OFS_DATA, i);
				t_done = $time;
			end
			begin
				repeat (150) @(posedge clk);
				t_rel = $time;
				stall <= 1'b0;
			end
		join
		chk(t_done > t_rel, 1'b1);
		wait_n(40);
		for (int i = 0; i < 40; i++) chk(u_snk.dq.pop_front(), i);
		apb(1'b0, sosp_pkg::OFS_STAT, 32'h0);
		chk(rd[sosp_pkg::STAT_EMPTY], 1'b1);
		u_snk.sq.delete();
		apb(1'b1, sosp_pkg::OFS_CTRL, 32'h2);
		stall <= 1'b1;
		apb(1'b1, sosp_pkg::OFS_DATA, 32'hdead);
		apb(1'b0, sosp_pkg::OFS_STAT, 32'h0);
		chk(rd[1:0], 2'b10);
		stall <= 1'b0;
		repeat (3) @(posedge clk);
		apb(1'b1, sosp_pkg::OFS_DATA, 32'hbeef);
		apb(1'b0, sosp_pkg::OFS_STAT, 32'h0);
		chk(rd[1:0], 2'b11);
		wait_n(1);
		chk(u_snk.dq.pop_front(), 32'hbeef);
		apb(1'b0, sosp_pkg::OFS_CNT, 32'h0);
		chk(rd, 32'd45);
		finish_test();
	end
endmodule
`default_nettype wire
